// [hdl/fcdc_device.sv]
// Device end: feature connector direction control with Wishbone registers
//
// The Wishbone register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module fcdc_device (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic [7:0] VIDEO_R,
	input wire logic [7:0] VIDEO_G,
	input wire logic [7:0] VIDEO_B,
	input wire logic INT_HSYNC,
	input wire logic INT_VSYNC,
	input wire logic INT_BLANK,
	output logic [7:0] ANALOG_RED_OUT,
	output logic [7:0] ANALOG_GREEN_OUT,
	output logic [7:0] ANALOG_BLUE_OUT,
	fcdc_if.device FC
);
	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [31:0] ctrl;
		logic [15:0] pix_out;
		logic [15:0] pix_in;
		logic [31:0] dat;
		logic ack;
		logic [5:0] s1;
		logic [5:0] s2;
		logic [2:0] alt_hist;
		logic [2:0] pclk_hist;
		logic [1:0] div;
		logic pclk_gen;
		logic en_n;
		logic hs_o;
		logic hs_oe;
		logic vs_o;
		logic vs_oe;
		logic bl_o;
		logic bl_oe;
		logic pc_oe;
		logic px_oe;
		logic [15:0] px_o;
		logic [23:0] rgb;
		logic [15:0] pix_s1;
		logic [15:0] pix_s2;
	} fcdc_dev_t;
	fcdc_dev_t st_reg, st_next;
	logic enable;
	logic feature;
	logic local_pixel_bus;
	logic sync_out;
	logic video_out;
	logic clock_out;
	logic alt_rise;
	logic pclk_rise;
	logic sample;
	logic [31:0] wdata;
	logic [31:0] pix_merge;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = dat[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		st_next = st_reg;
		// Pixel bus pins pass two flops before use
		st_next.pix_s1 = FC.pixel_bus;
		st_next.pix_s2 = st_reg.pix_s1;
		st_next.s1 = {FC.sync_dir_select, FC.video_dir_select,
			FC.clock_dir_select, FC.blank, FC.dac_power_down_in,
			FC.pixel_clock_in_alt};
		st_next.s2 = st_reg.s1;
		st_next.alt_hist = {st_reg.alt_hist[1:0], st_reg.s2[0]};
		st_next.pclk_hist = {st_reg.pclk_hist[1:0], FC.pixel_clock_io};
		enable = st_reg.ctrl[fcdc_pkg::CTRL_ENABLE_BIT];
		feature = st_reg.ctrl[fcdc_pkg::CTRL_FUNC_LO +: 2]
			== fcdc_pkg::FUNC_FEATURE;
		local_pixel_bus = enable && st_reg.ctrl[fcdc_pkg::CTRL_LPB_BIT];
		// ****************************************************************
		// Direction decode
		// ****************************************************************
		// Directions only follow the pins with pixel bus enabled
		sync_out = !local_pixel_bus || st_reg.s2[5];
		video_out = local_pixel_bus && st_reg.s2[4];
		clock_out = enable && (!local_pixel_bus || st_reg.s2[3]);
		alt_rise = st_reg.alt_hist[1] && !st_reg.alt_hist[2];
		pclk_rise = st_reg.pclk_hist[1] && !st_reg.pclk_hist[2];
		// Input bus sampled on the alt clock only if selected
		if (st_reg.ctrl[fcdc_pkg::CTRL_INCLK_BIT]) begin
			sample = alt_rise;
		end else if (st_reg.ctrl[fcdc_pkg::CTRL_TEST_BIT]
			&& !clock_out) begin
			sample = pclk_rise;
		end else begin
			sample = 1'b0;
		end
		if (local_pixel_bus && !video_out && sample) begin
			st_next.pix_in = st_reg.pix_s2;
		end
		st_next.en_n = !(enable && feature);
		st_next.hs_oe = enable && sync_out;
		st_next.vs_oe = enable && sync_out;
		st_next.bl_oe = enable && sync_out;
		st_next.hs_o = INT_HSYNC;
		st_next.vs_o = INT_VSYNC;
		st_next.bl_o = INT_BLANK;
		st_next.div = st_reg.div + 2'h1;
		if (st_reg.div == fcdc_pkg::PCLK_HALF) begin
			st_next.div = 2'h0;
			st_next.pclk_gen = !st_reg.pclk_gen;
		end
		st_next.pc_oe = clock_out;
		st_next.px_oe = video_out;
		st_next.px_o = st_reg.pix_out;
		// Video off on power down, or on external blank low with the local pixel bus enabled
		if (st_reg.s2[1] || (local_pixel_bus && !sync_out && !st_reg.s2[2])) begin
			st_next.rgb = 24'h000000;
		end else begin
			st_next.rgb = {VIDEO_R, VIDEO_G, VIDEO_B};
		end
		// ****************************************************************
		// Wishbone slave
		// ****************************************************************
		// Wishbone classic slave, one wait state, ack one cycle
		st_next.ack = WB_CYC_I && WB_STB_I && !st_reg.ack;
		wdata = 32'h0;
		pix_merge = merge({16'h0, st_reg.pix_out}, WB_DAT_I, WB_SEL_I);
		if (WB_ADR_I == fcdc_pkg::ADDR_CTRL) begin
			wdata = st_reg.ctrl;
			if (st_next.ack && WB_WE_I) begin
				st_next.ctrl = merge(st_reg.ctrl, WB_DAT_I, WB_SEL_I)
					& 32'h0000_003f;
			end
		end else if (WB_ADR_I == fcdc_pkg::ADDR_STATUS) begin
			wdata = {24'h0, st_reg.s2[5:1], video_out, sync_out,
				clock_out};
		end else if (WB_ADR_I == fcdc_pkg::ADDR_PIX_OUT) begin
			wdata = {16'h0, st_reg.pix_out};
			if (st_next.ack && WB_WE_I) begin
				st_next.pix_out = pix_merge[15:0];
			end
		end else if (WB_ADR_I == fcdc_pkg::ADDR_PIX_IN) begin
			wdata = {16'h0, st_reg.pix_in};
		end
		st_next.dat = st_next.ack ? wdata : 32'h0;
		// ****************************************************************
		// Reset
		// ****************************************************************
		if (!RESET_N) begin
			st_next = '0;
			st_next.ctrl = fcdc_pkg::CTRL_RESET;
			st_next.en_n = 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		st_reg <= st_next;
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign WB_DAT_O = st_reg.dat;
	assign WB_ACK_O = st_reg.ack;
	assign ANALOG_RED_OUT = st_reg.rgb[23:16];
	assign ANALOG_GREEN_OUT = st_reg.rgb[15:8];
	assign ANALOG_BLUE_OUT = st_reg.rgb[7:0];
	assign FC.connector_enable_out_n = st_reg.en_n;
	assign FC.hsync_dev_o = st_reg.hs_o;
	assign FC.hsync_dev_oe = st_reg.hs_oe;
	assign FC.vsync_dev_o = st_reg.vs_o;
	assign FC.vsync_dev_oe = st_reg.vs_oe;
	assign FC.blank_dev_o = st_reg.bl_o;
	assign FC.blank_dev_oe = st_reg.bl_oe;
	assign FC.pclk_dev_o = st_reg.pclk_gen;
	assign FC.pclk_dev_oe = st_reg.pc_oe;
	assign FC.pix_dev_o = st_reg.px_o;
	assign FC.pix_dev_oe = st_reg.px_oe;
endmodule : fcdc_device

// [hdl/fcdc_pkg.sv]
// Package of constants shared by both ends of the feature connector link
package fcdc_pkg;
	// ****************************************************************
	// Widths and register map
	// ****************************************************************
	localparam int PIX_W = 16;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_PIX_OUT = 8'h08;
	localparam logic [7:0] ADDR_PIX_IN = 8'h0c;
	// Device control register fields
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_INCLK_BIT = 1;
	localparam int CTRL_FUNC_LO = 2;
	localparam int CTRL_LPB_BIT = 4;
	localparam int CTRL_TEST_BIT = 5;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// Board control register fields
	localparam int BRD_SYNC_BIT = 0;
	localparam int BRD_VIDEO_BIT = 1;
	localparam int BRD_CLOCK_BIT = 2;
	localparam int BRD_BLANK_BIT = 3;
	localparam int BRD_HS_BIT = 4;
	localparam int BRD_VS_BIT = 5;
	localparam int BRD_DAC_POWER_DOWN_IN_BIT = 6;
	localparam logic [1:0] FUNC_FEATURE = 2'h0;
	// Pixel clock divider for the driving end, half period in CLK cycles minus one
	localparam logic [1:0] PCLK_HALF = 2'h3;
endpackage : fcdc_pkg

// [hdl/fcdc_if.sv]
// Interface carrying the feature connector pins between the two ends
`timescale 1ns/100ps
interface fcdc_if;
	logic sync_dir_select;
	logic video_dir_select;
	logic clock_dir_select;
	logic dac_power_down_in;
	logic connector_enable_out_n;
	logic hsync_dev_o, hsync_dev_oe, hsync_brd_o, hsync_brd_oe;
	logic vsync_dev_o, vsync_dev_oe, vsync_brd_o, vsync_brd_oe;
	logic blank_dev_o, blank_dev_oe, blank_brd_o, blank_brd_oe;
	logic pclk_dev_o, pclk_dev_oe, pclk_brd_o, pclk_brd_oe;
	logic [15:0] pix_dev_o, pix_brd_o;
	logic pix_dev_oe, pix_brd_oe;
	logic pixel_clock_in_alt;
	logic hsync, vsync, blank, pixel_clock_io;
	logic [15:0] pixel_bus;
	// Wire levels from the enables, sync and blank pulled high, pixel clock and pixel bus low when nobody drives
	assign hsync = hsync_dev_oe ? hsync_dev_o :
		(hsync_brd_oe ? hsync_brd_o : 1'b1);
	assign vsync = vsync_dev_oe ? vsync_dev_o :
		(vsync_brd_oe ? vsync_brd_o : 1'b1);
	assign blank = blank_dev_oe ? blank_dev_o :
		(blank_brd_oe ? blank_brd_o : 1'b1);
	assign pixel_clock_io = pclk_dev_oe ? pclk_dev_o :
		(pclk_brd_oe ? pclk_brd_o : 1'b0);
	assign pixel_bus = pix_dev_oe ? pix_dev_o :
		(pix_brd_oe ? pix_brd_o : 16'h0000);
	modport device (
		input sync_dir_select, video_dir_select, clock_dir_select,
		input dac_power_down_in, pixel_clock_in_alt,
		input hsync, vsync, blank, pixel_clock_io, pixel_bus,
		output connector_enable_out_n,
		output hsync_dev_o, hsync_dev_oe, vsync_dev_o, vsync_dev_oe,
		output blank_dev_o, blank_dev_oe, pclk_dev_o, pclk_dev_oe,
		output pix_dev_o, pix_dev_oe
	);
	modport board (
		output sync_dir_select, video_dir_select, clock_dir_select,
		output dac_power_down_in, pixel_clock_in_alt,
		input hsync, vsync, blank, pixel_clock_io, pixel_bus,
		input connector_enable_out_n,
		output hsync_brd_o, hsync_brd_oe, vsync_brd_o, vsync_brd_oe,
		output blank_brd_o, blank_brd_oe, pclk_brd_o, pclk_brd_oe,
		output pix_brd_o, pix_brd_oe
	);
endinterface : fcdc_if

// [hdl/fcdc_board.sv]
// Board end: external video board driving the connector control pins
`timescale 1ns/100ps
module fcdc_board (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic [7:0] CTRL_IN,
	input wire logic [15:0] PIX_IN,
	output logic [15:0] PIX_SEEN,
	output logic [2:0] SYNC_SEEN,
	output logic CONNECTOR_ON,
	fcdc_if.board FC
);
	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [7:0] ctrl;
		logic [15:0] pix;
		logic [15:0] seen;
		logic [2:0] syncs;
		logic en1, en2, on;
		logic [1:0] div;
		logic clk_alt;
		logic [15:0] pix_s1;
		logic [2:0] sync_s1;
	} fcdc_brd_t;
	fcdc_brd_t st_reg, st_next;

	always_comb begin
		st_next = st_reg;
		st_next.ctrl = CTRL_IN;
		st_next.pix = PIX_IN;
		// Connector pins pass two flops before use
		st_next.pix_s1 = FC.pixel_bus;
		st_next.sync_s1 = {FC.hsync, FC.vsync, FC.blank};
		st_next.seen = st_reg.pix_s1;
		st_next.syncs = st_reg.sync_s1;
		st_next.en1 = FC.connector_enable_out_n;
		st_next.en2 = st_reg.en1;
		st_next.on = !st_reg.en2;
		st_next.div = st_reg.div + 2'h1;
		if (st_reg.div == fcdc_pkg::PCLK_HALF) begin
			st_next.div = 2'h0;
			st_next.clk_alt = !st_reg.clk_alt;
		end
		if (!RESET_N) begin
			st_next = '0;
			st_next.ctrl[fcdc_pkg::BRD_SYNC_BIT] = 1'b1;
			st_next.ctrl[fcdc_pkg::BRD_VIDEO_BIT] = 1'b1;
			st_next.ctrl[fcdc_pkg::BRD_CLOCK_BIT] = 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		st_reg <= st_next;
	end

	// Direction controls and drivers released where the device drives
	assign FC.sync_dir_select = st_reg.ctrl[fcdc_pkg::BRD_SYNC_BIT];
	assign FC.video_dir_select = st_reg.ctrl[fcdc_pkg::BRD_VIDEO_BIT];
	assign FC.clock_dir_select = st_reg.ctrl[fcdc_pkg::BRD_CLOCK_BIT];
	assign FC.dac_power_down_in = st_reg.ctrl[fcdc_pkg::BRD_DAC_POWER_DOWN_IN_BIT];
	assign FC.pixel_clock_in_alt = st_reg.clk_alt;
	assign FC.hsync_brd_o = st_reg.ctrl[fcdc_pkg::BRD_HS_BIT];
	assign FC.vsync_brd_o = st_reg.ctrl[fcdc_pkg::BRD_VS_BIT];
	assign FC.blank_brd_o = st_reg.ctrl[fcdc_pkg::BRD_BLANK_BIT];
	assign FC.hsync_brd_oe = !st_reg.ctrl[fcdc_pkg::BRD_SYNC_BIT];
	assign FC.vsync_brd_oe = !st_reg.ctrl[fcdc_pkg::BRD_SYNC_BIT];
	assign FC.blank_brd_oe = !st_reg.ctrl[fcdc_pkg::BRD_SYNC_BIT];
	assign FC.pclk_brd_o = st_reg.clk_alt;
	assign FC.pclk_brd_oe = !st_reg.ctrl[fcdc_pkg::BRD_CLOCK_BIT];
	assign FC.pix_brd_o = st_reg.pix;
	assign FC.pix_brd_oe = !st_reg.ctrl[fcdc_pkg::BRD_VIDEO_BIT];
	assign PIX_SEEN = st_reg.seen;
	assign SYNC_SEEN = st_reg.syncs;
	assign CONNECTOR_ON = st_reg.on;
endmodule : fcdc_board

// [test/fcdc_monitor.sv]
// Checker of the feature connector pins between the two ends
`timescale 1ns/100ps
module fcdc_monitor (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic sync_dir_select,
	input wire logic video_dir_select,
	input wire logic clock_dir_select,
	input wire logic connector_enable_out_n,
	input wire logic hsync_dev_oe,
	input wire logic vsync_dev_oe,
	input wire logic blank_dev_oe,
	input wire logic hsync_brd_oe,
	input wire logic blank_brd_oe,
	input wire logic pclk_dev_oe,
	input wire logic pix_dev_oe,
	input wire logic pix_brd_oe,
	input wire logic pixel_clock_io
);
	default clocking mon_cb @(posedge CLK);
	endclocking
	default disable iff (!RESET_N);
	// ****************************************************************
	// Pin direction checks
	// ****************************************************************
	sync_input_a: assert property (
		!sync_dir_select [*4] |-> !hsync_dev_oe)
		else $error("device drives sync while it is an input");
	sync_group_a: assert property (
		hsync_dev_oe == vsync_dev_oe && hsync_dev_oe == blank_dev_oe)
		else $error("sync and blank drivers disagree");
	pix_input_a: assert property (
		!video_dir_select [*4] |-> !pix_dev_oe)
		else $error("device drives pixel bus while it is an input");
	clk_input_a: assert property (
		!clock_dir_select [*4] |-> !pclk_dev_oe)
		else $error("device drives pixel clock while it is an input");
	feature_on_a: assert property (
		(!connector_enable_out_n && sync_dir_select) [*4] |->
		hsync_dev_oe && vsync_dev_oe && blank_dev_oe)
		else $error("connector enabled without its sync drivers");
	brd_sync_a: assert property (
		sync_dir_select [*4] |-> !hsync_brd_oe && !blank_brd_oe)
		else $error("board drives sync while device owns it");
	brd_pix_a: assert property (
		video_dir_select [*4] |-> !pix_brd_oe)
		else $error("board drives pixel bus while device owns it");
	pclk_half_a: assert property (
		$past(pclk_dev_oe) && pclk_dev_oe && $changed(pixel_clock_io)
		|=> $stable(pixel_clock_io) || !pclk_dev_oe)
		else $error("pixel clock half period too short");
	pix_in_c: cover property (pix_brd_oe);
	pclk_out_c: cover property (pclk_dev_oe);
	sync_in_c: cover property (hsync_brd_oe);
endmodule : fcdc_monitor

// [test/fcdc_tb_top.sv]
// Bench joining the device and board ends of the feature connector
`timescale 1ns/100ps
module fcdc_tb_top;
	logic clk = 1'b0, reset_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic ack, hs = 1'b0, vs = 1'b0, bl = 1'b1, con, pb;
	logic [7:0] adr = 8'h00, vr = 8'h5a, vg = 8'h3c, vb = 8'h81, ctl = 8'h0f;
	logic [7:0] ar, ag, ab;
	logic [3:0] sel = 4'hf;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic [15:0] pin = 16'h0, pseen, pv;
	logic [2:0] sseen;
	integer seed = 61831, n_errors = 0, n_checks = 0, cycles = 0, i, e;
	always #10 clk = ~clk;
	fcdc_if u_fcdc_if ();
	fcdc_device u_fcdc_device (.CLK(clk), .RESET_N(reset_n), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
		.WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .VIDEO_R(vr),
		.VIDEO_G(vg), .VIDEO_B(vb), .INT_HSYNC(hs), .INT_VSYNC(vs),
		.INT_BLANK(bl), .ANALOG_RED_OUT(ar), .ANALOG_GREEN_OUT(ag),
		.ANALOG_BLUE_OUT(ab), .FC(u_fcdc_if.device));
	fcdc_board u_fcdc_board (.CLK(clk), .RESET_N(reset_n), .CTRL_IN(ctl),
		.PIX_IN(pin), .PIX_SEEN(pseen), .SYNC_SEEN(sseen),
		.CONNECTOR_ON(con), .FC(u_fcdc_if.board));
	fcdc_monitor u_fcdc_monitor (.CLK(clk), .RESET_N(reset_n),
		.sync_dir_select(u_fcdc_if.sync_dir_select),
		.video_dir_select(u_fcdc_if.video_dir_select),
		.clock_dir_select(u_fcdc_if.clock_dir_select),
		.connector_enable_out_n(u_fcdc_if.connector_enable_out_n),
		.hsync_dev_oe(u_fcdc_if.hsync_dev_oe),
		.vsync_dev_oe(u_fcdc_if.vsync_dev_oe),
		.blank_dev_oe(u_fcdc_if.blank_dev_oe),
		.hsync_brd_oe(u_fcdc_if.hsync_brd_oe),
		.blank_brd_oe(u_fcdc_if.blank_brd_oe),
		.pclk_dev_oe(u_fcdc_if.pclk_dev_oe), .pix_dev_oe(u_fcdc_if.pix_dev_oe),
		.pix_brd_oe(u_fcdc_if.pix_brd_oe),
		.pixel_clock_io(u_fcdc_if.pixel_clock_io));
	// ****************************************************************
	// Helpers
	// ****************************************************************
	function logic fen(input logic [31:0] c);
		return !(c[fcdc_pkg::CTRL_ENABLE_BIT] && c[3:2] == fcdc_pkg::FUNC_FEATURE);
	endfunction : fen
	function logic [31:0] stat(input logic [7:0] c);
		return {24'h0, c[0], c[1], c[2], c[3], c[6], c[1], c[0], c[2]};
	endfunction : stat
	task end_of_test();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_of_test
	task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		n_checks = n_checks + 1;
		if (s !== x) begin
			n_errors = n_errors + 1;
			$display("unexpected %s: expected %h seen %h", nm, x, s);
		end
	endtask : chk
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hf;
		adr <= a;
		wdat <= d;
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task cfg(input logic [7:0] v, input integer n);
		@(posedge clk);
		ctl <= v;
		repeat (n) @(posedge clk);
	endtask : cfg
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			n_errors = n_errors + 1;
			end_of_test();
		end
	end
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		vr <= 8'($random(seed));
		vg <= 8'($random(seed));
		vb <= 8'($random(seed));
		wb(1'b0, fcdc_pkg::ADDR_CTRL, 32'h0);
		chk("ctrl reset", q, fcdc_pkg::CTRL_RESET);
		chk("enable_n reset", u_fcdc_if.connector_enable_out_n, 1'b1);
		wb(1'b1, 8'h10, 32'hffff_ffff);
		wb(1'b0, 8'h10, 32'h0);
		chk("unmapped", q, 32'h0);
		for (i = 0; i < 8; i++) begin
			e = {i[1:0], 1'b0, i[2]};
			wb(1'b1, fcdc_pkg::ADDR_CTRL, e);
			wb(1'b0, fcdc_pkg::ADDR_CTRL, 32'h0);
			chk("ctrl", q, e);
			cfg(8'h0f, 8);
			chk("enable_n", u_fcdc_if.connector_enable_out_n, fen(e));
			chk("board enable", con, !fen(e));
		end
		for (i = 0; i < 3; i++) begin
			e = (i == 0) ? 32'h10 : (i == 1) ? 32'h01 : 32'h11;
			wb(1'b1, fcdc_pkg::ADDR_CTRL, e);
			cfg(8'h0f, 8);
			chk("pix drive", u_fcdc_if.pix_dev_oe, i == 2);
		end
		for (i = 0; i < 4; i++) begin
			pv = (i == 0) ? 16'hffff : 16'($random(seed));
			wb(1'b1, fcdc_pkg::ADDR_PIX_OUT, {16'h0000, pv});
			cfg(8'h0f, 6);
			chk("bus out", u_fcdc_if.pixel_bus, pv);
			chk("board pixels", pseen, pv);
		end
		hs <= 1'b1;
		cfg(8'h0f, 8);
		chk("syncs out", sseen, 3'h5);
		cfg(8'h06, 8);
		chk("sync released", u_fcdc_if.hsync_dev_oe, 1'b0);
		chk("syncs in", sseen, 3'h0);
		chk("video off", {ar, ag, ab}, 24'h0);
		cfg(8'h0e, 8);
		chk("video on", {ar, ag, ab}, {vr, vg, vb});
		wb(1'b0, fcdc_pkg::ADDR_STATUS, 32'h0);
		chk("status out", q, stat(8'h0e));
		e = 0;
		for (i = 0; i < 64; i++) begin
			pb = u_fcdc_if.pixel_clock_io;
			@(posedge clk);
			if (!pb && u_fcdc_if.pixel_clock_io) e++;
		end
		chk("pclk edges", e, 8);
		cfg(8'h4e, 8);
		chk("power down", {ar, ag, ab}, 24'h0);
		cfg(8'h0a, 8);
		chk("pclk released", u_fcdc_if.pclk_dev_oe, 1'b0);
		wb(1'b1, fcdc_pkg::ADDR_CTRL, 32'h13);
		pin <= 16'($random(seed));
		cfg(8'h08, 40);
		chk("pix released", u_fcdc_if.pix_dev_oe, 1'b0);
		wb(1'b0, fcdc_pkg::ADDR_PIX_IN, 32'h0);
		chk("capture", q[15:0], pin);
		pv = pin;
		wb(1'b1, fcdc_pkg::ADDR_CTRL, 32'h11);
		pin <= ~pv;
		cfg(8'h08, 40);
		wb(1'b0, fcdc_pkg::ADDR_PIX_IN, 32'h0);
		chk("no capture", q[15:0], pv);
		wb(1'b1, fcdc_pkg::ADDR_CTRL, 32'h31);
		cfg(8'h08, 40);
		wb(1'b0, fcdc_pkg::ADDR_PIX_IN, 32'h0);
		chk("test capture", q[15:0], 16'(~pv));
		wb(1'b0, fcdc_pkg::ADDR_STATUS, 32'h0);
		chk("status in", q, stat(8'h08));
		end_of_test();
	end
endmodule : fcdc_tb_top
